// file: ttd_tone_detectors.sv
// Purpose: Digit, calling-tone, alert-tone and call-progress detector control and results.
// Assumes: Front ends return per-tick measurements for the source each selects.
// Notes: Register port is the internal side of the serial control interface.
// Contract
// - Recognise all sixteen digit tone pairs.
// - Digit valid follows recognition, clears when disabled.
// - Valid pair writes 5-bit code into control.
// - Dial-tone filter path chosen by enable bit.
// - Each detector has enable and source select.
// - Twist and level limits gate digit reporting.
// - Calling tone uses 1100/1300 Hz bands.
// - Calling tone needs level and burst exceeded.
// - Calling tone input resolution reduced by parameter.
// - Calling-tone flag set on valid tone.
// - Alert detector watches 2130/2750 Hz tones.
// - Alert mode, deviation select, 8-bit level.
// - Alert detected sets flag and 2-bit code.
// - Progress detector watches 340-640 Hz band.
// - Raw mode reports band hits that pass level and noise ratio directly.
// - Cooked flag sets on burst after count.
// - Flag unchanged by reads, sticky until disabled.
// - Checker enforces burst, gap and difference limits.
// - Violation resets cycle count, restarts next burst.
// - Burst needs minimum level and noise ratio.
// - Controller reads status and results via port.
`timescale 1ns/1ps
`include "ttd_defs.svh"
module ttd_tone_detectors (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic proc_tick,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire ttd_pkg::ttd_dd_meas_t dd_raw,
	input wire ttd_pkg::ttd_dd_meas_t dd_filt,
	input wire ttd_pkg::ttd_cng_meas_t cng_meas,
	input wire ttd_pkg::ttd_at_meas_t at_meas,
	input wire ttd_pkg::ttd_cpt_meas_t cpt_meas,
	output logic [4:0] dd_src,
	output logic dial_tone_filter_enable,
	output logic [4:0] cng_src,
	output logic [4:0] at_src,
	output logic deviation_select,
	output logic [4:0] cpt_src,
	output ttd_pkg::ttd_status_t status
);
	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	// Writable configuration words, indexed by register offset.
	logic [15:0] cfg_q [0:`TTD_NUM_CFG-1];
	// Bits that read back; reserved bits read as zero.
	localparam logic [15:0] RMASK [0:`TTD_NUM_CFG-1] = '{16'h007f, 16'h7fff, 16'h003f, 16'h003f,
		16'hffff, 16'hffff, 16'hffff, 16'h003f, 16'h03ff, 16'h007f, 16'hffff, 16'hffff, 16'hffff, 16'h7fff};
	logic [4:0] digit_tone_code_q; // Last recognised digit code.
	logic [1:0] alert_tone_code_q; // Last recognised alert combination.
	logic digit_valid_flag_q; // Digit currently recognised.
	logic cng_flag_q; // Calling tone detected.
	logic alert_detected_flag_q; // Alert tone detected.
	logic cpt_flag_q; // Call-progress tone detected.
	logic [15:0] cng_cnt_q; // Calling-tone burst length in ticks.
	logic [15:0] rdata_q; // Read data register.

	// Named views of the configuration words.
	logic dd_en;
	logic dd_enf;
	logic cng_en;
	logic at_en;
	logic cpt_en;
	logic cpt_raw;
	logic [15:0] dd_ctl;
	logic [15:0] at_ctl;
	logic [15:0] at_cfg;
	logic [15:0] cpt_tr;

	assign dd_ctl = cfg_q[`TTD_OFF_DIGIT_DETECTOR_CONTROL];
	assign at_ctl = cfg_q[`TTD_OFF_ATCTL];
	assign at_cfg = cfg_q[`TTD_OFF_ATCFG];
	assign cpt_tr = cfg_q[`TTD_OFF_PROGRESS_TRIGGER_CONFIG];
	assign dd_en = dd_ctl[`TTD_EN];
	assign dd_enf = dd_ctl[`TTD_DD_ENF];
	assign cng_en = cfg_q[`TTD_OFF_CALLING_TONE_CONTROL][`TTD_EN];
	assign at_en = at_ctl[`TTD_EN];
	assign cpt_en = cfg_q[`TTD_OFF_PROGRESS_TONE_CONTROL][`TTD_EN];
	// A set mode bit selects raw progress mode.
	assign cpt_raw = cfg_q[`TTD_OFF_PROGRESS_TONE_CONTROL][`TTD_CPT_MD];

	// Register writes; the status word and result fields ignore writes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `TTD_NUM_CFG; i++) begin
				cfg_q[i] <= `TTD_RST_REG;
			end
		end else if (reg_wr && reg_addr < 4'(`TTD_NUM_CFG)) begin
			cfg_q[reg_addr] <= reg_wdata;
		end
	end

	// Read data, one cycle after the read strobe; reading has no side effect.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `TTD_RST_REG;
		end else if (reg_rd) begin
			case (reg_addr)
				`TTD_OFF_DIGIT_DETECTOR_CONTROL: begin
					rdata_q <= (dd_ctl & RMASK[`TTD_OFF_DIGIT_DETECTOR_CONTROL]) | {4'h0, digit_tone_code_q, 7'h00};
				end
				`TTD_OFF_ATCTL: begin
					rdata_q <= (at_ctl & RMASK[`TTD_OFF_ATCTL]) | {8'h00, alert_tone_code_q, 6'h00};
				end
				`TTD_OFF_STATUS: begin
					// Flag positions: dtv bit 0, cng 1, alert 2, progress 3.
					rdata_q <= {12'h000, status};
				end
				default: begin
					if (reg_addr < 4'(`TTD_NUM_CFG)) rdata_q <= cfg_q[reg_addr] & RMASK[reg_addr];
					else rdata_q <= `TTD_RST_REG;
				end
			endcase
		end
	end

	// Control outputs, registered copies of the configuration fields.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dd_src <= 5'h00;
			dial_tone_filter_enable <= 1'b0;
			cng_src <= 5'h00;
			at_src <= 5'h00;
			deviation_select <= 1'b0;
			cpt_src <= 5'h00;
		end else begin
			dd_src <= dd_ctl[`TTD_DD_SRC];
			dial_tone_filter_enable <= dd_enf;
			cng_src <= cfg_q[`TTD_OFF_CALLING_TONE_CONTROL][`TTD_SRC];
			at_src <= at_ctl[`TTD_SRC];
			deviation_select <= at_cfg[`TTD_AT_DEV];
			cpt_src <= cfg_q[`TTD_OFF_PROGRESS_TONE_CONTROL][`TTD_CPT_SRC];
		end
	end

	assign reg_rdata = rdata_q;
	assign status = '{cpt: cpt_flag_q, alert_detected_flag: alert_detected_flag_q, cng: cng_flag_q, digit_valid_flag: digit_valid_flag_q};

	// ------------------------------------------------------------------------
	// Digit detector
	// ------------------------------------------------------------------------
	ttd_pkg::ttd_dd_meas_t dd_m; // Result of the path in use.
	logic dd_ok; // Valid pair within limits.

	// The filtered path is used only while the filter is enabled.
	assign dd_m = dd_enf ? dd_filt : dd_raw;
	// Pairs with excess twist or low level are not reported.
	assign dd_ok = dd_m.present && dd_m.level >= cfg_q[`TTD_OFF_DIGIT_MIN_LEVEL][`TTD_DIGIT_MIN_LEVEL]
		&& dd_m.twist <= cfg_q[`TTD_OFF_DIGIT_TWIST_LIMIT][`TTD_TWIST];

	// Flag follows recognition each tick; code holds the last valid pair.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			digit_valid_flag_q <= 1'b0;
			digit_tone_code_q <= 5'h00;
		end else if (!dd_en) begin
			digit_valid_flag_q <= 1'b0;
		end else if (proc_tick) begin
			digit_valid_flag_q <= dd_ok;
			// All sixteen row and column pairs map to distinct codes.
			if (dd_ok) digit_tone_code_q <= {1'b0, dd_m.row, dd_m.col};
		end
	end

	// ------------------------------------------------------------------------
	// Calling-tone detector
	// ------------------------------------------------------------------------
	logic [15:0] cng_lvl; // Level after resolution reduction.
	logic cng_on; // Either band present above level.

	// Low bits are dropped as set by the resolution field.
	assign cng_lvl = cng_meas.level & (`TTD_FULL_MASK << cfg_q[`TTD_OFF_CALLING_TONE_RESOLUTION][`TTD_RES]);
	// The two bands are the 1100 Hz and 1300 Hz filters.
	assign cng_on = (cng_meas.hit_lo || cng_meas.hit_hi) && cng_lvl > cfg_q[`TTD_OFF_CALLING_TONE_MIN_LEVEL];

	// Burst length counts while the tone lasts; flag sets once it exceeds the minimum.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cng_cnt_q <= 16'h0000;
			cng_flag_q <= 1'b0;
		end else if (!cng_en) begin
			cng_cnt_q <= 16'h0000;
			cng_flag_q <= 1'b0;
		end else if (proc_tick) begin
			if (!cng_on) cng_cnt_q <= 16'h0000;
			else if (cng_cnt_q != `TTD_FULL_MASK) cng_cnt_q <= cng_cnt_q + 16'h0001;
			if (cng_on && cng_cnt_q > cfg_q[`TTD_OFF_CALLING_TONE_MIN_BURST]) cng_flag_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Alert-tone detector
	// ------------------------------------------------------------------------
	logic at_tones; // Required tones present for the mode.
	logic at_ok; // Valid alert tone.

	// A set mode bit asks for single tones; clear asks for both tones.
	assign at_tones = at_cfg[`TTD_AT_MD] ? (at_meas.hit_lo || at_meas.hit_hi) : (at_meas.hit_lo && at_meas.hit_hi);
	// Deviation select set allows 1.1 percent, clear allows 0.5 percent.
	assign at_ok = at_tones && (deviation_select ? at_meas.dev_wide : at_meas.dev_narrow)
		&& at_meas.level >= at_cfg[`TTD_AT_MIN];

	// Flag follows detection; code bit 0 is 2130 Hz, bit 1 is 2750 Hz.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_detected_flag_q <= 1'b0;
			alert_tone_code_q <= 2'h0;
		end else if (!at_en) begin
			alert_detected_flag_q <= 1'b0;
		end else if (proc_tick) begin
			alert_detected_flag_q <= at_ok;
			if (at_ok) alert_tone_code_q <= {at_meas.hit_hi, at_meas.hit_lo};
		end
	end

	// ------------------------------------------------------------------------
	// Call-progress detector
	// ------------------------------------------------------------------------
	logic cpt_burst; // Band signal counts as a burst.
	logic cpt_hit; // Cooked-mode result of the timing checker.

	// Band is the 340 to 640 Hz filter; level and noise ratio must pass.
	assign cpt_burst = cpt_meas.band && cpt_meas.level >= cpt_tr[`TTD_CPT_MIN] && cpt_meas.snr >= cpt_tr[`TTD_CPT_SN];

	// Timing checker runs only in cooked mode; raw mode ignores the cycle count.
	ttd_cpt_timer #(.W(8), .NW(3)) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.en(cpt_en && !cpt_raw),
		.tick(proc_tick),
		.burst(cpt_burst),
		.min_burst_time(cfg_q[`TTD_OFF_PROGRESS_MIN_TIMES][`TTD_LO8]),
		.min_gap_time(cfg_q[`TTD_OFF_PROGRESS_MIN_TIMES][`TTD_HI8]),
		.max_burst_time(cfg_q[`TTD_OFF_PROGRESS_MAX_TIMES][`TTD_LO8]),
		.max_gap_time(cfg_q[`TTD_OFF_PROGRESS_MAX_TIMES][`TTD_HI8]),
		.burst_difference_limit(cfg_q[`TTD_OFF_PROGRESS_MAX_DIFFERENCES][`TTD_LO8]),
		.gap_difference_limit(cfg_q[`TTD_OFF_PROGRESS_MAX_DIFFERENCES][`TTD_HI8]),
		.num(cpt_tr[`TTD_CPT_NUM]),
		.hit(cpt_hit)
	);

	// Raw mode mirrors the burst per tick; cooked mode takes the sticky checker result.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpt_flag_q <= 1'b0;
		end else if (!cpt_en) begin
			cpt_flag_q <= 1'b0;
		end else if (cpt_raw) begin
			if (proc_tick) cpt_flag_q <= cpt_burst;
		end else begin
			cpt_flag_q <= cpt_hit;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_dtv_off;
		@(posedge clk) disable iff (!rst_n) !dd_en |=> !status.digit_valid_flag;
	endproperty
	a_dtv_off: assert property (p_dtv_off) else $error("digit flag set while disabled");

	property p_dtv_code;
		@(posedge clk) disable iff (!rst_n) dd_en && proc_tick && dd_ok |=> status.digit_valid_flag
			&& digit_tone_code_q == {1'b0, $past(dd_m.row), $past(dd_m.col)};
	endproperty
	a_dtv_code: assert property (p_dtv_code) else $error("digit code not captured");

	property p_dtv_limits;
		@(posedge clk) disable iff (!rst_n) dd_en && proc_tick
			&& dd_m.twist > cfg_q[`TTD_OFF_DIGIT_TWIST_LIMIT][`TTD_TWIST] |=> !status.digit_valid_flag;
	endproperty
	a_dtv_limits: assert property (p_dtv_limits) else $error("digit reported beyond twist");

	property p_cng_cause;
		@(posedge clk) disable iff (!rst_n) $rose(status.cng) |-> $past(cng_cnt_q > cfg_q[`TTD_OFF_CALLING_TONE_MIN_BURST] && cng_on);
	endproperty
	a_cng_cause: assert property (p_cng_cause) else $error("calling flag without long burst");

	property p_at_code;
		@(posedge clk) disable iff (!rst_n) $rose(status.alert_detected_flag) |-> alert_tone_code_q != 2'h0;
	endproperty
	a_at_code: assert property (p_at_code) else $error("alert flag with empty code");

	property p_cpt_raw;
		@(posedge clk) disable iff (!rst_n) cpt_en && cpt_raw && proc_tick |=> status.cpt == $past(cpt_burst);
	endproperty
	a_cpt_raw: assert property (p_cpt_raw) else $error("raw progress flag wrong");

	property p_cpt_read;
		@(posedge clk) disable iff (!rst_n) status.cpt && cpt_en && !cpt_raw && reg_rd && !reg_wr |=> status.cpt;
	endproperty
	a_cpt_read: assert property (p_cpt_read) else $error("progress flag changed by read");
endmodule

// file: ttd_defs.svh
// Purpose: Register offsets, field positions and reset values of the tone detectors.
// Assumes: Registers are 16 bits wide and addressed by a 4-bit register index.
// Notes: Included by the detector and timing checker files; definitions only.
`ifndef TTD_DEFS_SVH
`define TTD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define TTD_OFF_DIGIT_DETECTOR_CONTROL 4'h0
`define TTD_OFF_DIGIT_TWIST_LIMIT 4'h1
`define TTD_OFF_DIGIT_MIN_LEVEL 4'h2
`define TTD_OFF_CALLING_TONE_CONTROL 4'h3
`define TTD_OFF_CALLING_TONE_MIN_LEVEL 4'h4
`define TTD_OFF_CALLING_TONE_MIN_BURST 4'h5
`define TTD_OFF_CALLING_TONE_RESOLUTION 4'h6
`define TTD_OFF_ATCTL 4'h7
`define TTD_OFF_ATCFG 4'h8
`define TTD_OFF_PROGRESS_TONE_CONTROL 4'h9
`define TTD_OFF_PROGRESS_MIN_TIMES 4'ha
`define TTD_OFF_PROGRESS_MAX_TIMES 4'hb
`define TTD_OFF_PROGRESS_MAX_DIFFERENCES 4'hc
`define TTD_OFF_PROGRESS_TRIGGER_CONFIG 4'hd
`define TTD_OFF_STATUS 4'he
`define TTD_NUM_CFG 14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TTD_EN 0
`define TTD_SRC 5:1
`define TTD_DD_ENF 1
`define TTD_DD_SRC 6:2
`define TTD_DD_CODE 11:7
`define TTD_AT_CODE 7:6
`define TTD_AT_MD 0
`define TTD_AT_DEV 1
`define TTD_AT_MIN 9:2
`define TTD_CPT_MD 1
`define TTD_CPT_SRC 6:2
`define TTD_LO8 7:0
`define TTD_HI8 15:8
`define TTD_TWIST 14:0
`define TTD_DIGIT_MIN_LEVEL 5:0
`define TTD_RES 3:0
`define TTD_CPT_NUM 2:0
`define TTD_CPT_MIN 10:3
`define TTD_CPT_SN 14:11

// ----------------------------------------------------------------------------
// Reset values and fixed constants
// ----------------------------------------------------------------------------
`define TTD_RST_REG 16'h0000
`define TTD_FULL_MASK 16'hffff
`endif

// file: ttd_pkg.sv
// Purpose: Types shared by the tone detector files.
// Assumes: Measurement front ends deliver one result per processing tick.
// Notes: Nothing here holds a number of the register map.
package ttd_pkg;

	// Digit front-end result for the selected input.
	typedef struct packed {
		logic present;
		logic [1:0] row;
		logic [1:0] col;
		logic [5:0] level;
		logic [14:0] twist;
	} ttd_dd_meas_t;

	// Calling-tone band hits (low and high band) and band level.
	typedef struct packed {
		logic hit_lo;
		logic hit_hi;
		logic [15:0] level;
	} ttd_cng_meas_t;

	// Alert-tone hits with deviation class and level.
	typedef struct packed {
		logic hit_lo;
		logic hit_hi;
		logic dev_narrow;
		logic dev_wide;
		logic [7:0] level;
	} ttd_at_meas_t;

	// Call-progress band result.
	typedef struct packed {
		logic band;
		logic [7:0] level;
		logic [3:0] snr;
	} ttd_cpt_meas_t;

	// Status word flags.
	typedef struct packed {
		logic cpt;
		logic alert_detected_flag;
		logic cng;
		logic digit_valid_flag;
	} ttd_status_t;

	// Timing checker states, Gray coded along idle, burst, gap.
	typedef enum logic [1:0] {
		TTD_IDLE = 2'b00,
		TTD_BURST = 2'b01,
		TTD_GAP = 2'b11
	} ttd_cpt_state_t;
endpackage

// file: ttd_cpt_timer.sv
// Purpose: Burst and gap timing checker of the call-progress detector.
// Assumes: Durations are counted in processing ticks.
// Notes: The hit output is sticky until the enable drops.
`timescale 1ns/1ps
`include "ttd_defs.svh"
module ttd_cpt_timer #(parameter int W = 8, parameter int NW = 3) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic tick,
	input wire logic burst,
	input wire logic [W-1:0] min_burst_time,
	input wire logic [W-1:0] min_gap_time,
	input wire logic [W-1:0] max_burst_time,
	input wire logic [W-1:0] max_gap_time,
	input wire logic [W-1:0] burst_difference_limit,
	input wire logic [W-1:0] gap_difference_limit,
	input wire logic [NW-1:0] num,
	output logic hit
);
	ttd_pkg::ttd_cpt_state_t st_q; // Checker state.
	logic [W-1:0] len_q; // Length of the current burst or gap.
	logic [W-1:0] prevb_q; // Length of the previous burst.
	logic [W-1:0] prevg_q; // Length of the previous gap.
	logic hasb_q; // A previous burst exists.
	logic hasg_q; // A previous gap exists.
	logic [NW-1:0] cyc_q; // Completed cycles.
	logic was_burst_q; // Burst seen at the previous tick, so the tail of a rejected burst is not a new one.
	logic bok; // Finished burst is within its limits.
	logic gok; // Finished gap is within its limits.
	logic last; // The next cycle completes the programmed count.

	// Absolute difference of two lengths.
	function automatic logic [W-1:0] adiff(input logic [W-1:0] a, input logic [W-1:0] b);
		adiff = (a > b) ? a - b : b - a;
	endfunction

	assign bok = len_q >= min_burst_time && len_q <= max_burst_time && (!hasb_q || adiff(len_q, prevb_q) <= burst_difference_limit);
	assign gok = len_q >= min_gap_time && len_q <= max_gap_time && (!hasg_q || adiff(len_q, prevg_q) <= gap_difference_limit);
	assign last = ({1'b0, cyc_q} + 1'b1) == {1'b0, num};

	// ------------------------------------------------------------------------
	// Sequence tracking
	// ------------------------------------------------------------------------
	// A violation clears the history so that counting starts again.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ttd_pkg::TTD_IDLE;
			len_q <= '0;
			prevb_q <= '0;
			prevg_q <= '0;
			hasb_q <= 1'b0;
			hasg_q <= 1'b0;
			cyc_q <= '0;
			hit <= 1'b0;
			was_burst_q <= 1'b0;
		end else if (!en) begin
			// Disabling returns the checker to idle at once.
			st_q <= ttd_pkg::TTD_IDLE;
			hasb_q <= 1'b0;
			hasg_q <= 1'b0;
			cyc_q <= '0;
			hit <= 1'b0;
			was_burst_q <= 1'b0;
		end else if (tick) begin
			was_burst_q <= burst;
			case (st_q)
				ttd_pkg::TTD_IDLE: begin
					// A new sequence starts only on the rising edge of a burst.
					if (burst && !was_burst_q) begin
						st_q <= ttd_pkg::TTD_BURST;
						len_q <= W'(1);
						if (num == '0) hit <= 1'b1;
					end
				end
				ttd_pkg::TTD_BURST: begin
					if (burst && len_q != max_burst_time) begin
						len_q <= len_q + 1'b1;
					end else if (!burst && bok) begin
						st_q <= ttd_pkg::TTD_GAP;
						prevb_q <= len_q;
						hasb_q <= 1'b1;
						len_q <= W'(1);
					end else begin
						// Burst too short, too long or too different.
						st_q <= ttd_pkg::TTD_IDLE;
						hasb_q <= 1'b0;
						hasg_q <= 1'b0;
						cyc_q <= '0;
					end
				end
				ttd_pkg::TTD_GAP: begin
					if (!burst && len_q != max_gap_time) begin
						len_q <= len_q + 1'b1;
					end else if (burst && gok) begin
						// A cycle is complete; the new burst may set the flag.
						st_q <= ttd_pkg::TTD_BURST;
						prevg_q <= len_q;
						hasg_q <= 1'b1;
						len_q <= W'(1);
						if (last || hit) hit <= 1'b1;
						else cyc_q <= cyc_q + 1'b1;
					end else if (burst) begin
						// Bad gap: this burst becomes the first of a new sequence.
						st_q <= ttd_pkg::TTD_BURST;
						len_q <= W'(1);
						hasb_q <= 1'b0;
						hasg_q <= 1'b0;
						cyc_q <= '0;
					end else begin
						st_q <= ttd_pkg::TTD_IDLE;
						hasb_q <= 1'b0;
						hasg_q <= 1'b0;
						cyc_q <= '0;
					end
				end
				default: st_q <= ttd_pkg::TTD_IDLE;
			endcase
		end
	end

	property p_hit_sticky;
		@(posedge clk) disable iff (!rst_n) hit && en |=> hit;
	endproperty
	a_hit_sticky: assert property (p_hit_sticky) else $error("cooked flag fell while enabled");

	property p_hit_off;
		@(posedge clk) disable iff (!rst_n) !en |=> !hit && st_q == ttd_pkg::TTD_IDLE;
	endproperty
	a_hit_off: assert property (p_hit_off) else $error("checker not idle after disable");
endmodule

// file: ttd_ctrl_model.sv
// Purpose: Controller model that reaches the detector registers over the register port.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes: Address and data carry the inverse of the last value while no request is made.
`timescale 1ns/1ps
module ttd_ctrl_model (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [3:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	// Idle port at time zero.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
	end

	// One write: held over one rising edge, then released.
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask

	// One read: the answer stands from the edge after the request.
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		v = reg_rdata;
	endtask

	// Raw mode always goes with a zero cycle count.
	task automatic raw_mode(input logic [15:0] trig, input logic [15:0] ctl);
		wr(4'hd, {trig[15:3], 3'h0});
		wr(4'h9, ctl);
	endtask
endmodule

// file: ttd_tone_detectors_tb_top.sv
// Purpose: Self-checking bench of the tone detector control block.
// Assumes: Inputs change at the falling edge; one measurement per tick.
// Notes: Front ends are replaced by measurement structs driven here.
`timescale 1ns/1ps
module ttd_tone_detectors_tb_top;
	logic clk, rst_n, proc_tick, reg_wr, reg_rd;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	ttd_pkg::ttd_dd_meas_t dd_raw, dd_filt;
	ttd_pkg::ttd_cng_meas_t cng_meas;
	ttd_pkg::ttd_at_meas_t at_meas;
	ttd_pkg::ttd_cpt_meas_t cpt_meas;
	logic [4:0] dd_src, cng_src, at_src, cpt_src;
	logic dial_tone_filter_enable, deviation_select;
	ttd_pkg::ttd_status_t status;
	int failures, n_tests;
	// Digit cases: filter select, level, twist, tone present, expected valid flag.
	typedef struct packed {logic f; logic [5:0] lev; logic [14:0] tw; logic pres; logic digit_valid_flag;} ttd_row_t;
	ttd_row_t rows [6] = '{'{1'b0, 6'h08, 15'h0064, 1'b1, 1'b1}, '{1'b0, 6'h07, 15'h0064, 1'b1, 1'b0},
		'{1'b0, 6'h08, 15'h0065, 1'b1, 1'b0}, '{1'b0, 6'h08, 15'h0064, 1'b0, 1'b0},
		'{1'b1, 6'h08, 15'h0064, 1'b1, 1'b0}, '{1'b1, 6'h08, 15'h0064, 1'b0, 1'b1}};

	ttd_tone_detectors uut (.clk(clk), .rst_n(rst_n), .proc_tick(proc_tick), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dd_raw(dd_raw), .dd_filt(dd_filt),
		.cng_meas(cng_meas), .at_meas(at_meas), .cpt_meas(cpt_meas), .dd_src(dd_src),
		.dial_tone_filter_enable(dial_tone_filter_enable), .cng_src(cng_src), .at_src(at_src),
		.deviation_select(deviation_select), .cpt_src(cpt_src), .status(status));
	ttd_ctrl_model ctl (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// Clock of 100 ns period.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// Processing ticks; the extra edge lets the cooked flag copy land.
	task automatic tk(input int n);
		repeat (n) begin
			@(negedge clk);
			proc_tick = 1'b1;
			@(negedge clk);
			proc_tick = 1'b0;
			@(negedge clk);
		end
	endtask

	// One burst of progress tone, then a gap.
	task automatic burst(input int on, input int off);
		cpt_meas = '{1'b1, 8'd5, 4'd2};
		tk(on);
		cpt_meas = '{1'b0, 8'd5, 4'd2};
		tk(off);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

	// Main sequence.
	initial begin
		failures = 0;
		n_tests = 0;
		rst_n = 1'b0;
		proc_tick = 1'b0;
		dd_raw = '0;
		dd_filt = '0;
		cng_meas = '0;
		at_meas = '0;
		cpt_meas = '0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		// All words read zero after reset, unmapped and status writes are ignored.
		ctl.wr(4'he, 16'hffff);
		ctl.wr(4'hf, 16'hffff);
		for (int a = 0; a < 16; a++) begin
			ctl.rd(a[3:0], d);
			chk(d, 16'h0000);
		end
		// Digit limits and filter path from the table.
		ctl.wr(4'h1, 16'h0064);
		ctl.wr(4'h2, 16'h0008);
		foreach (rows[i]) begin
			ctl.wr(4'h0, {14'h000a, rows[i].f, 1'b1});
			dd_raw = '{rows[i].pres, 2'h2, 2'h1, rows[i].lev, rows[i].tw};
			dd_filt = dd_raw;
			dd_filt.present = ~rows[i].pres;
			tk(1);
			chk(16'(status.digit_valid_flag), 16'(rows[i].digit_valid_flag));
			chk(16'(dial_tone_filter_enable), 16'(rows[i].f));
			chk(16'(dd_src), 16'h000a);
		end
		// Every one of the sixteen pairs yields its code.
		ctl.wr(4'h0, 16'h0029);
		dd_filt = '0;
		for (int k = 0; k < 16; k++) begin
			dd_raw = '{1'b1, k[3:2], k[1:0], 6'h3f, 15'h0000};
			tk(1);
			ctl.rd(4'h0, d);
			chk(16'(d[11:7]), 16'(k[3:0]));
			chk(16'(status.digit_valid_flag), 16'h0001);
		end
		dd_raw.present = 1'b0;
		tk(1);
		chk(16'(status.digit_valid_flag), 16'h0000);
		dd_raw.present = 1'b1;
		tk(1);
		ctl.wr(4'h0, 16'h0000);
		repeat (2) @(negedge clk);
		chk(16'(status.digit_valid_flag), 16'h0000);
		// Calling tone: level must exceed the minimum, then a long enough burst.
		ctl.wr(4'h4, 16'd100);
		ctl.wr(4'h5, 16'd2);
		ctl.wr(4'h6, 16'h0000);
		ctl.wr(4'h3, 16'h0007);
		@(negedge clk);
		chk(16'(cng_src), 16'h0003);
		cng_meas = '{1'b1, 1'b1, 16'd100};
		tk(6);
		chk(16'(status.cng), 16'h0000);
		cng_meas = '0;
		tk(1);
		cng_meas = '{1'b1, 1'b1, 16'd101};
		tk(1);
		chk(16'(status.cng), 16'h0000);
		tk(4);
		chk(16'(status.cng), 16'h0001);
		cng_meas = '0;
		tk(2);
		chk(16'(status.cng), 16'h0001);
		ctl.wr(4'h3, 16'h0000);
		repeat (2) @(negedge clk);
		chk(16'(status.cng), 16'h0000);
		// Alert tone: dual mode, then single mode with wide deviation.
		ctl.wr(4'h8, 16'h0028);
		ctl.wr(4'h7, 16'h0009);
		at_meas = '{1'b1, 1'b1, 1'b1, 1'b0, 8'd9};
		tk(1);
		chk(16'(status.alert_detected_flag), 16'h0000);
		at_meas.level = 8'd10;
		tk(1);
		ctl.rd(4'h7, d);
		chk({status.alert_detected_flag, d[7:6], at_src, deviation_select}, {1'b1, 2'b11, 5'h04, 1'b0});
		ctl.wr(4'h8, 16'h002b);
		at_meas = '{1'b0, 1'b1, 1'b0, 1'b1, 8'd10};
		tk(1);
		ctl.rd(4'h7, d);
		chk({status.alert_detected_flag, d[7:6], deviation_select}, {1'b1, 2'b10, 1'b1});
		// Progress tone in raw mode follows each tick.
		ctl.raw_mode(16'h1028, 16'h001b);
		@(negedge clk);
		chk(16'(cpt_src), 16'h0006);
		cpt_meas = '{1'b1, 8'd5, 4'd2};
		tk(1);
		chk(16'(status.cpt), 16'h0001);
		cpt_meas.snr = 4'd1;
		tk(1);
		chk(16'(status.cpt), 16'h0000);
		cpt_meas = '{1'b1, 8'd4, 4'd2};
		tk(1);
		chk(16'(status.cpt), 16'h0000);
		cpt_meas = '{1'b0, 8'd5, 4'd2};
		tk(1);
		chk(16'(status.cpt), 16'h0000);
		// Cooked mode, one cycle: an overlong burst restarts the count.
		ctl.wr(4'h9, 16'h0000);
		ctl.wr(4'ha, 16'h0202);
		ctl.wr(4'hb, 16'h0505);
		ctl.wr(4'hc, 16'h0303);
		ctl.wr(4'hd, 16'h1029);
		ctl.wr(4'h9, 16'h0019);
		burst(8, 3);
		burst(3, 3);
		chk(16'(status.cpt), 16'h0000);
		burst(3, 0);
		chk(16'(status.cpt), 16'h0001);
		burst(0, 9);
		ctl.rd(4'he, d);
		chk({d[3], status.cpt}, 2'b11);
		ctl.wr(4'h9, 16'h0000);
		repeat (2) @(negedge clk);
		chk(16'(status.cpt), 16'h0000);
		complete_run();
	end
endmodule
